// ===== verilog/sbg_driver.sv
`timescale 1ns/1ps
// Operation
// - Serial bits shift into a register; 34 parallel outputs show the stored pattern.
// - Only two link signals: serial data and a qualifying clock.
// - A frame is one start bit of one, then 35 data bits.
// - Outputs load only after the 36th clocked bit, never earlier.
// - Outputs are static, unmultiplexed, held until the next full frame.
// - No external reset pin; misalignment persists until power is cycled.
module sbg_driver (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        link_clk,
  input  wire logic        serial_data,
  output logic [33:0]      seg_out
);
  // rst_b models power-on only; there is no user reset at the link
  logic [5:0]  bit_cnt_q;
  logic [34:0] shift_q;
  logic [33:0] frame_q;
  logic        frame_tgl_q;
  logic        frame_tgl_s;
  logic        seen_tgl_q;
  logic        link_rst_b;
  logic [1:0]  lrst_q;
  logic        link_run_q;

  // Frame-end decode, shared by the counter, the capture and the checks
  // Count runs 0 to 35, so the 36th link edge meets the top value
  function automatic logic is_frame_end(input logic [5:0] cnt);
    return cnt == sbg_pkg::LAST_BIT;
  endfunction : is_frame_end

  // Power-on reset released into the link domain
  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end
  assign link_rst_b = lrst_q[1];

  // Check window opens one link edge after release
  // Keeps history-based checks off the reset-held counter values
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      link_run_q <= 1'b0;
    end else begin
      link_run_q <= 1'b1;
    end
  end

  // Bit position in frame, sampled on rising link edge
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      bit_cnt_q <= sbg_pkg::CNT_RESET;
    end else if (is_frame_end(bit_cnt_q)) begin
      bit_cnt_q <= sbg_pkg::CNT_RESET;
    end else begin
      bit_cnt_q <= bit_cnt_q + 6'h01; // no resync: miscount persists
    end
  end

  // Shift register, data moves toward higher outputs
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      shift_q <= sbg_pkg::SHIFT_RESET;
    end else begin
      shift_q <= {shift_q[33:0], serial_data};
    end
  end

  // Capture on the 36th bit, then signal by toggle
  always_ff @(posedge link_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      frame_q     <= sbg_pkg::OUT_RESET;
      frame_tgl_q <= 1'b0;
    end else if (is_frame_end(bit_cnt_q)) begin
      // shift_q[34] is the start bit, [33] the first data bit; the 36th bit
      // is the final clock and its data is ignored, so [33:0] maps directly
      frame_q     <= shift_q[33:0];
      frame_tgl_q <= ~frame_tgl_q;
    end
  end

  // Only the toggle crosses; the frame word is stable for a whole frame
  // after it, so the system side may read it once the toggle arrives
  sbg_sync u_tgl_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (frame_tgl_q),
    .dout  (frame_tgl_s)
  );

  // Load outputs on toggle arrival; frame_q is stable long before
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      seen_tgl_q <= 1'b0;
      seg_out    <= sbg_pkg::OUT_RESET;
    end else begin
      seen_tgl_q <= frame_tgl_s;
      if (frame_tgl_s != seen_tgl_q) begin
        seg_out <= frame_q;
      end
    end
  end

  // Link domain checks
  // Disabled until one live edge has passed, except a_lrst_chain, so history is never reset state
  sequence s_frame_end;
    is_frame_end(bit_cnt_q);
  endsequence

  sequence s_mid_frame;
    !is_frame_end(bit_cnt_q);
  endsequence

  property p_cnt_wrap;
    @(posedge link_clk) disable iff (!link_run_q)
      s_frame_end |=> bit_cnt_q == 6'h00;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap) else $error("count did not wrap");

  property p_cnt_step;
    @(posedge link_clk) disable iff (!link_run_q)
      s_mid_frame |=> bit_cnt_q == $past(bit_cnt_q) + 6'h01;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("count skipped");

  property p_cnt_range;
    @(posedge link_clk) disable iff (!link_run_q)
      bit_cnt_q <= sbg_pkg::LAST_BIT;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("count out of frame");

  property p_latch_only_end;
    @(posedge link_clk) disable iff (!link_run_q)
      $changed(frame_tgl_q) |-> $past(bit_cnt_q) == sbg_pkg::LAST_BIT;
  endproperty
  a_latch_only_end: assert property (p_latch_only_end) else $error("early latch");

  property p_tgl_flip;
    @(posedge link_clk) disable iff (!link_run_q)
      s_frame_end |=> frame_tgl_q != $past(frame_tgl_q);
  endproperty
  a_tgl_flip: assert property (p_tgl_flip) else $error("frame end not signalled");

  property p_latch_end;
    @(posedge link_clk) disable iff (!link_run_q)
      s_frame_end |=> frame_q == $past(shift_q[33:0]);
  endproperty
  a_latch_end: assert property (p_latch_end) else $error("frame not captured");

  property p_frame_hold;
    @(posedge link_clk) disable iff (!link_run_q)
      s_mid_frame |=> $stable(frame_q);
  endproperty
  a_frame_hold: assert property (p_frame_hold) else $error("frame word moved");

  property p_shift_in;
    @(posedge link_clk) disable iff (!link_run_q)
      1'b1 |=> shift_q[0] == $past(serial_data) && shift_q[34:1] == $past(shift_q[33:0]);
  endproperty
  a_shift_in: assert property (p_shift_in) else $error("shift wrong");

  property p_lrst_chain;
    @(posedge link_clk) disable iff (!rst_b)
      link_rst_b |-> lrst_q[0];
  endproperty
  a_lrst_chain: assert property (p_lrst_chain) else $error("link release out of order");

  // System domain checks
  sequence s_tgl_new;
    frame_tgl_s != seen_tgl_q;
  endsequence

  property p_out_load;
    @(posedge mclk) disable iff (!rst_b)
      s_tgl_new |=> seg_out == $past(frame_q);
  endproperty
  a_out_load: assert property (p_out_load) else $error("outputs not loaded");

  property p_out_hold;
    @(posedge mclk) disable iff (!rst_b)
      !(frame_tgl_s != seen_tgl_q) |=> $stable(seg_out);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("outputs changed");

  property p_tgl_track;
    @(posedge mclk) disable iff (!rst_b)
      s_tgl_new |=> frame_tgl_s == seen_tgl_q ##1 frame_tgl_s == seen_tgl_q;
  endproperty
  a_tgl_track: assert property (p_tgl_track) else $error("event seen twice");

  // Outputs move only on a fresh frame event
  property p_out_only_event;
    @(posedge mclk) disable iff (!rst_b)
      $changed(seg_out) |-> $past(frame_tgl_s != seen_tgl_q);
  endproperty
  a_out_only_event: assert property (p_out_only_event) else $error("stray output change");

  // Frames are far apart, so a new event never follows closely
  property p_tgl_gap;
    @(posedge mclk) disable iff (!rst_b)
      s_tgl_new |=> (frame_tgl_s == seen_tgl_q) [*4];
  endproperty
  a_tgl_gap: assert property (p_tgl_gap) else $error("events too close");
endmodule : sbg_driver

// ===== verilog/sbg_pkg.sv
package sbg_pkg;
  // Frame geometry
  localparam int unsigned OUT_COUNT   = 34;
  localparam int unsigned DATA_BITS   = 35;
  localparam int unsigned FRAME_BITS  = 36;
  localparam int unsigned CNT_W       = 6;
  localparam logic [5:0]  LAST_BIT    = 6'h23;
  localparam logic [5:0]  CNT_RESET   = 6'h00;
  // Reset values
  localparam logic [33:0] OUT_RESET   = 34'h0;
  localparam logic [34:0] SHIFT_RESET = 35'h0;
  // Synchroniser depth for link-domain events
  localparam int unsigned SYNC_STAGES = 3;
  // Clock figures
  localparam int unsigned MCLK_HZ     = 20000000;
endpackage : sbg_pkg

// ===== verilog/sbg_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree
module sbg_sync (
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic din,
  output logic      dout
);
  logic [2:0] stage_q;

  // Shift chain; stage 0 is read only by stage 1
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stage_q <= 3'h0;
    end else begin
      stage_q <= {stage_q[1:0], din};
    end
  end

  // Hold last agreed value
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dout <= 1'b0;
    end else if (stage_q[1] == stage_q[2]) begin
      dout <= stage_q[2];
    end
  end
endmodule : sbg_sync

// ===== verif/sbg_host.sv
`timescale 1ns/1ps
// Host write decode: one link clock per write
module sbg_host (
  output logic link_clk,
  output logic serial_data
);
  initial link_clk = 1'b0;
  initial serial_data = 1'b0;
  // One write: data bit, 32 ns set-up, then a 32 ns clock pulse
  task automatic wr(input logic b);
    serial_data = b;
    #32 link_clk = 1'b1;
    #32 link_clk = 1'b0;
    serial_data = ~b; // Held value gone
  endtask : wr
  // Start bit, pattern high end first, then final clock
  task automatic frame(input logic [33:0] p);
    wr(1'b1);
    for (int i = 33; i >= 0; i--) wr(p[i]);
    wr(1'($urandom));
  endtask : frame
endmodule : sbg_host

// ===== verif/serial_bar_graph_driver_tb.sv
`timescale 1ns/1ps
// Host model drives the link, queue holds expected outputs
module serial_bar_graph_driver_tb;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic        link_clk;
  logic        serial_data;
  logic [33:0] seg_out;
  logic [33:0] last = '0;
  logic [33:0] exp_q[$];
  int          bad_count;
  int          samples_checked;
  always #25 mclk = ~mclk;
  sbg_driver dut_u (.mclk(mclk), .rst_b(rst_b), .link_clk(link_clk),
    .serial_data(serial_data), .seg_out(seg_out));
  sbg_host host_u (.link_clk(link_clk), .serial_data(serial_data));
  task automatic check(string n, logic [33:0] s, logic [33:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d bad %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  // Each output change takes the oldest note
  always @(posedge mclk) begin
    #1;
    if (seg_out !== last) begin
      last = seg_out;
      if (exp_q.size() == 0) check("early seg_out", seg_out, ~seg_out);
      else check("seg_out", seg_out, exp_q.pop_front());
    end
  end
  // Bounded wait for the noted result
  task automatic wait_drain;
    for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(negedge mclk);
    if (exp_q.size() > 0) begin
      bad_count++;
      stop_test();
    end
  endtask : wait_drain
  // Full frame, note pattern only after the final clock
  task automatic send(logic [33:0] p);
    if (p === last) p = ~p;
    host_u.frame(p);
    exp_q.push_back(p);
    wait_drain();
    repeat (8) @(negedge mclk);
  endtask : send
  // Release reset, two link clocks for the link side
  task automatic relink;
    @(negedge mclk);
    rst_b = 1'b1;
    host_u.wr(1'b0);
    host_u.wr(1'b0);
  endtask : relink
  initial begin
    int cnt[5] = '{34, 0, 1, 33, 17};
    void'($urandom(32'ha86cc14c));
    repeat (10) @(negedge mclk);
    relink();
    foreach (cnt[k]) send((34'h1 << cnt[k]) - 34'h1);
    $display("bar test done");
    for (int k = 0; k < 4; k++) send(34'({$urandom(), $urandom()}));
    $display("pattern test done");
    repeat (20) host_u.wr(1'($urandom));
    @(negedge mclk);
    rst_b = 1'b0;
    exp_q.push_back('0);
    host_u.wr(1'b0);
    host_u.wr(1'b0);
    wait_drain();
    repeat (4) @(negedge mclk);
    relink();
    send(34'h2aaaaaaaa);
    $display("reset test done");
    stop_test();
  end
endmodule : serial_bar_graph_driver_tb
